// [include/fhr_pkg.sv]
`default_nettype none
package fhr_pkg;
    // register addresses on the 10-bit i/o bus
    localparam logic [9:0] ADDR_RATE_STATUS = 10'h03f4;
    localparam logic [9:0] ADDR_DATA = 10'h03f5;
    // rate_write_delay_select_control layout
    localparam logic [7:0] RATE_CTRL_RESET = 8'h02;
    localparam int RATE_LSB = 0;
    localparam int WRITE_DELAY_SELECT_LSB = 2;
    localparam int RSVD_BIT = 5;
    localparam int LOWPWR_BIT = 6;
    localparam int SWRST_BIT = 7;
    // controller_handshake_status layout
    localparam int SEEK_LSB = 0;
    localparam int CMD_BUSY_BIT = 4;
    localparam int POLLED_BIT = 5;
    localparam int DIR_BIT = 6;
    localparam int REQ_BIT = 7;
    // rate codes
    localparam logic [1:0] RATE_1M = 2'h3;
    localparam logic [1:0] RATE_500 = 2'h0;
    localparam logic [1:0] RATE_300 = 2'h1;
    localparam logic [1:0] RATE_250 = 2'h2;
    localparam logic [1:0] DRT_STD = 2'h0;
    localparam logic [1:0] DRT_3MODE = 2'h1;
    localparam logic [1:0] DRT_2M = 2'h2;
    // write_delay_select codes and delays in steps of the base unit (41.67 ns, or 20.8 ns at 2 Mbps)
    localparam logic [2:0] WRITE_DELAY_SELECT_ZERO = 3'h7;
    localparam logic [2:0] WRITE_DELAY_SELECT_DEFAULT = 3'h0;
    localparam logic [2:0] STEPS_DEF_FAST = 3'h1;
    localparam logic [2:0] STEPS_DEF_SLOW = 3'h3;
    localparam logic [2:0] STEPS_NONE = 3'h0;
    // drive type codes
    localparam logic [1:0] DT_STD = 2'h0;
    localparam logic [1:0] DT_RATE = 2'h2;
    localparam logic [1:0] DT_INV = 2'h1;
    localparam logic [1:0] DT_SWAP = 2'h3;
endpackage
`default_nettype wire

// [include/fhr_if.sv]
`default_nettype none
interface fhr_if;
    logic [9:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic wr;
    logic rd;
    modport dev (input addr, input wdata, input wr, input rd, output rdata);
    modport host (output addr, output wdata, output wr, output rd, input rdata);
endinterface
`default_nettype wire

// [rtl/fhr_dev.sv]
`default_nettype none
module fhr_dev (
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic ce_i,
    fhr_if.dev bus,
    input wire logic cfg_rate_wr_i,
    input wire logic [1:0] cfg_rate_i,
    input wire logic [1:0] drive_rate_setting_i,
    input wire logic [1:0] drive_type_code_i,
    input wire logic [7:0] write_delay_select_track_i,
    input wire logic [7:0] cur_track_i,
    input wire logic two_meg_i,
    input wire logic [3:0] drive_seeking_flag_i,
    input wire logic cmd_busy_i,
    input wire logic polled_exec_flag_i,
    input wire logic transfer_direction_i,
    input wire logic host_request_flag_i,
    input wire logic exec_start_i,
    input wire logic fifo_cfg_wr_i,
    input wire logic fifo_cfg_en_i,
    input wire logic xfer_error_i,
    input wire logic [7:0] result_byte_i,
    output logic [1:0] rate_code_o,
    output logic density_select_out_o,
    output logic [1:0] drive_density_pins_o,
    output logic [2:0] write_delay_select_steps_o,
    output logic write_delay_select_fine_o,
    output logic low_power_o,
    output logic soft_reset_o,
    output logic fifo_enable_o,
    output logic fifo_clear_o,
    output logic cmd_abort_o,
    output logic data_wr_o,
    output logic [7:0] data_byte_o,
    output logic data_rd_o
);
    logic [7:0] rate_ctrl_reg;
    logic [1:0] rate_reg;
    logic low_power_reg;
    logic soft_reset_reg;
    logic fifo_en_reg;
    logic [7:0] data_byte_reg;
    logic [7:0] status;
    logic wr_rs, rd_rs, wr_d, rd_d;
    logic [2:0] pc, pc_code;

    // decode of the two host addresses
    assign wr_rs = bus.wr && bus.addr == fhr_pkg::ADDR_RATE_STATUS;
    assign rd_rs = bus.rd && bus.addr == fhr_pkg::ADDR_RATE_STATUS;
    assign wr_d = bus.wr && bus.addr == fhr_pkg::ADDR_DATA;
    assign rd_d = bus.rd && bus.addr == fhr_pkg::ADDR_DATA;

    // rate/write_delay_select register; bit 5 stored as written, host keeps it zero
    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
            rate_ctrl_reg <= fhr_pkg::RATE_CTRL_RESET;
        else if (ce_i && wr_rs)
        begin
            rate_ctrl_reg <= bus.wdata;
            rate_ctrl_reg[fhr_pkg::SWRST_BIT] <= 1'b0;
        end
    end

    // active rate: last writer wins, soft reset does not touch it
    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
            rate_reg <= fhr_pkg::RATE_250;
        else if (ce_i && wr_rs)
            rate_reg <= bus.wdata[fhr_pkg::RATE_LSB +: 2];
        else if (ce_i && cfg_rate_wr_i)
            rate_reg <= cfg_rate_i;
    end

    // soft reset pulse, cleared the next cycle
    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
            soft_reset_reg <= 1'b0;
        else if (ce_i)
            soft_reset_reg <= wr_rs && bus.wdata[fhr_pkg::SWRST_BIT];
    end

    // manual low power; a status read, any data access or a soft reset wakes, a fresh power-down write wins a tie
    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
            low_power_reg <= 1'b0;
        else if (ce_i)
        begin
            if (wr_rs && bus.wdata[fhr_pkg::LOWPWR_BIT])
                low_power_reg <= 1'b1;
            else if (soft_reset_reg || rd_rs || wr_d || rd_d)
                low_power_reg <= 1'b0;
        end
    end

    // fifo mode: off after either reset until configured; soft reset waits for the enable
    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
            fifo_en_reg <= 1'b0;
        else if (ce_i && soft_reset_reg)
            fifo_en_reg <= 1'b0;
        else if (ce_i && fifo_cfg_wr_i)
            fifo_en_reg <= fifo_cfg_en_i;
    end

    // latch host data byte for the command engine
    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
            data_byte_reg <= 8'h00;
        else if (ce_i && wr_d && host_request_flag_i)
            data_byte_reg <= bus.wdata;
    end

    // handshake status assembly
    always_comb
    begin
        status = 8'h00;
        status[fhr_pkg::SEEK_LSB +: 4] = drive_seeking_flag_i;
        status[fhr_pkg::CMD_BUSY_BIT] = cmd_busy_i;
        status[fhr_pkg::POLLED_BIT] = polled_exec_flag_i && cmd_busy_i;
        status[fhr_pkg::DIR_BIT] = transfer_direction_i && host_request_flag_i;
        status[fhr_pkg::REQ_BIT] = host_request_flag_i;
    end

    // read mux: status any time, data byte from engine
    assign bus.rdata = rd_rs ? status : (rd_d ? result_byte_i : 8'h00);

    // write_delay_select code field of the rate register
    assign pc_code = rate_ctrl_reg[fhr_pkg::WRITE_DELAY_SELECT_LSB +: 3];

    // write_delay_select selection; below start track no delay is applied
    always_comb
    begin
        if (cur_track_i < write_delay_select_track_i || pc_code == fhr_pkg::WRITE_DELAY_SELECT_ZERO)
            pc = fhr_pkg::STEPS_NONE;
        else if (pc_code == fhr_pkg::WRITE_DELAY_SELECT_DEFAULT)
            pc = (two_meg_i || rate_reg == fhr_pkg::RATE_1M) ? fhr_pkg::STEPS_DEF_FAST
                : fhr_pkg::STEPS_DEF_SLOW;
        else
            pc = pc_code;
    end

    // density: follows the rate code alone, so the 3-mode 500 setting on code 01 keeps it low
    always_comb
    begin
        density_select_out_o = (rate_reg == fhr_pkg::RATE_1M) || (rate_reg == fhr_pkg::RATE_500);
        case (drive_type_code_i)
            fhr_pkg::DT_STD: drive_density_pins_o = {rate_reg[0], density_select_out_o};
            fhr_pkg::DT_RATE: drive_density_pins_o = {rate_reg[0], rate_reg[1]};
            fhr_pkg::DT_INV: drive_density_pins_o = {rate_reg[0], ~density_select_out_o};
            default: drive_density_pins_o = {rate_reg[1], rate_reg[0]};
        endcase
    end

    // 2M reachable through two_meg_i, or as rate code 01 with drive-rate 10
    assign write_delay_select_fine_o = two_meg_i || (rate_reg == fhr_pkg::RATE_300 && drive_rate_setting_i == fhr_pkg::DRT_2M);
    assign write_delay_select_steps_o = pc;
    assign rate_code_o = rate_reg;
    assign low_power_o = low_power_reg;
    assign soft_reset_o = soft_reset_reg;
    assign fifo_enable_o = fifo_en_reg;
    assign fifo_clear_o = exec_start_i;
    assign cmd_abort_o = xfer_error_i;
    assign data_wr_o = ce_i && wr_d && host_request_flag_i;
    assign data_byte_o = data_byte_reg;
    assign data_rd_o = ce_i && rd_d && host_request_flag_i;
endmodule
`default_nettype wire

// [rtl/fhr_host.sv]
`default_nettype none
module fhr_host (
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic ce_i,
    fhr_if.host bus,
    input wire logic req_i,
    input wire logic req_write_i,
    input wire logic req_rate_i,
    input wire logic [7:0] req_data_i,
    output logic busy_o,
    output logic done_o,
    output logic [7:0] rdata_o,
    output logic [7:0] status_o
);
    typedef enum {ST_IDLE, ST_POLL, ST_XFER} fhr_hst_t;
    fhr_hst_t state_reg;
    logic wr_reg, rate_reg;
    logic [7:0] data_reg, rdata_reg, status_reg;
    logic done_reg;

    // command sequencing: poll status before each data byte
    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
        begin
            state_reg <= ST_IDLE;
            wr_reg <= 1'b0;
            rate_reg <= 1'b0;
            data_reg <= 8'h00;
            rdata_reg <= 8'h00;
            status_reg <= 8'h00;
            done_reg <= 1'b0;
        end
        else if (ce_i)
        begin
            done_reg <= 1'b0;
            case (state_reg)
                ST_IDLE:
                    if (req_i)
                    begin
                        wr_reg <= req_write_i;
                        rate_reg <= req_rate_i;
                        data_reg <= rate_reg_mask(req_rate_i, req_data_i);
                        state_reg <= req_rate_i ? ST_XFER : ST_POLL;
                    end
                ST_POLL:
                begin
                    status_reg <= bus.rdata;
                    if (bus.rdata[fhr_pkg::REQ_BIT])
                        state_reg <= ST_XFER;
                end
                ST_XFER:
                begin
                    if (!wr_reg)
                        rdata_reg <= bus.rdata;
                    done_reg <= 1'b1;
                    state_reg <= ST_IDLE;
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // clears the undefined bit 5 of rate writes
    function automatic logic [7:0] rate_reg_mask(input logic is_rate, input logic [7:0] d);
        rate_reg_mask = d;
        if (is_rate)
            rate_reg_mask[fhr_pkg::RSVD_BIT] = 1'b0;
    endfunction

    // bus strobes follow the state
    assign bus.addr = (state_reg == ST_XFER && !rate_reg) ? fhr_pkg::ADDR_DATA : fhr_pkg::ADDR_RATE_STATUS;
    assign bus.rd = ce_i && (state_reg == ST_POLL || (state_reg == ST_XFER && !wr_reg));
    assign bus.wr = ce_i && state_reg == ST_XFER && wr_reg;
    assign bus.wdata = data_reg;
    assign busy_o = state_reg != ST_IDLE;
    assign done_o = done_reg;
    assign rdata_o = rdata_reg;
    assign status_o = status_reg;
endmodule
`default_nettype wire

// [bench/fhr_chk.sv]
`default_nettype none
// watches the shared host bus between the two ends
module fhr_chk (
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic [9:0] addr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic wr,
    input wire logic rd
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (srst_i);
    logic st_rd;
    // a status poll, used by several checks
    assign st_rd = rd && addr == 10'h03f4;
    strobe_excl_a: assert property (!(wr && rd))
        else $error("read and write strobes together");
    addr_map_a: assert property ((wr || rd) |-> (addr == 10'h03f4 || addr == 10'h03f5))
        else $error("access outside the two mapped offsets");
    rate_bit5_a: assert property ((wr && addr == 10'h03f4) |-> !wdata[5])
        else $error("rate write with bit 5 set");
    data_gate_a: assert property (((wr || rd) && addr == 10'h03f5) |-> $past(st_rd && rdata[7]))
        else $error("data access without a granting poll");
    wr_single_a: assert property (wr |=> !wr)
        else $error("write strobe longer than one cycle");
    polled_busy_a: assert property ((st_rd && rdata[5]) |-> rdata[4])
        else $error("polled flag outside a command");
    dir_gate_a: assert property ((st_rd && rdata[6]) |-> rdata[7])
        else $error("direction shown without request");
    reset_idle_a: assert property ($fell(srst_i) |-> !wr && !rd)
        else $error("bus strobe at reset release");
endmodule
`default_nettype wire

// [bench/test_floppy_host_rate_status_fifo_regs.sv]
`default_nettype none
module test_floppy_host_rate_status_fifo_regs;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys_i = 1'b0, srst_i = 1'b1, ce_i = 1'b1, cfg_rate_wr_i = 1'b0, two_meg_i = 1'b0, cmd_busy_i = 1'b0;
    logic polled_exec_flag_i = 1'b0, transfer_direction_i = 1'b0, host_request_flag_i = 1'b0, exec_start_i = 1'b0;
    logic fifo_cfg_wr_i = 1'b0, fifo_cfg_en_i = 1'b0, xfer_error_i = 1'b0, req_i = 1'b0, req_write_i = 1'b0;
    logic req_rate_i = 1'b0, b;
    logic [1:0] cfg_rate_i = 2'h0, drive_rate_setting_i = 2'h0, drive_type_code_i = 2'h0;
    logic [3:0] drive_seeking_flag_i = 4'h0;
    logic [7:0] write_delay_select_track_i = 8'h00, cur_track_i = 8'h00, result_byte_i = 8'h00, req_data_i = 8'h00, v, st;
    logic [1:0] rate_code_o, drive_density_pins_o;
    logic [2:0] write_delay_select_steps_o;
    logic [7:0] data_byte_o, rdata_o, status_o;
    logic density_select_out_o, write_delay_select_fine_o, low_power_o, soft_reset_o, fifo_enable_o, fifo_clear_o;
    logic cmd_abort_o, data_wr_o, data_rd_o, busy_o, done_o;
    int seed = 25424, fail_count = 0, samples_checked = 0, soft_count = 0;
    logic [9:0] exp_q[$];
    logic [9:0] note;
    fhr_if bus_if();
    fhr_dev i_fhr_dev (.clk_sys_i, .srst_i, .ce_i, .bus(bus_if), .cfg_rate_wr_i, .cfg_rate_i, .drive_rate_setting_i,
        .drive_type_code_i, .write_delay_select_track_i, .cur_track_i, .two_meg_i, .drive_seeking_flag_i, .cmd_busy_i,
        .polled_exec_flag_i, .transfer_direction_i, .host_request_flag_i, .exec_start_i, .fifo_cfg_wr_i,
        .fifo_cfg_en_i, .xfer_error_i, .result_byte_i, .rate_code_o, .density_select_out_o, .drive_density_pins_o,
        .write_delay_select_steps_o, .write_delay_select_fine_o, .low_power_o, .soft_reset_o, .fifo_enable_o, .fifo_clear_o,
        .cmd_abort_o, .data_wr_o, .data_byte_o, .data_rd_o);
    fhr_host i_fhr_host (.clk_sys_i, .srst_i, .ce_i, .bus(bus_if), .req_i, .req_write_i, .req_rate_i, .req_data_i,
        .busy_o, .done_o, .rdata_o, .status_o);
    fhr_chk i_fhr_chk (.clk_sys_i, .srst_i, .addr(bus_if.addr), .wdata(bus_if.wdata), .rdata(bus_if.rdata),
        .wr(bus_if.wr), .rd(bus_if.rd));
    // 100 ns period
    always #50 clk_sys_i = ~clk_sys_i;
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask
    // one host request; waits for done_o, bounded so a stuck handshake ends the run
    task automatic host_op(input logic wr_en, input logic rate, input logic [7:0] data);
        int n = 0;
        req_write_i = wr_en;
        req_rate_i = rate;
        req_data_i = data;
        req_i = 1'b1;
        @(negedge clk_sys_i);
        req_i = 1'b0;
        while (done_o !== 1'b1 && n < 200)
        begin
            @(negedge clk_sys_i);
            n++;
        end
        if (n >= 200)
        begin
            fail_count++;
            report_and_stop();
        end
        @(negedge clk_sys_i);
    endtask
    // density hangs on the rate code alone, the drive-rate setting plays no part
    function automatic logic dens_f(input logic [1:0] r);
        return r == fhr_pkg::RATE_1M || r == fhr_pkg::RATE_500;
    endfunction
    function automatic logic [1:0] pins_f(input logic [1:0] r, input logic [1:0] t, input logic d);
        case (t)
            fhr_pkg::DT_STD: return {r[0], d};
            fhr_pkg::DT_RATE: return {r[0], r[1]};
            fhr_pkg::DT_INV: return {r[0], ~d};
            default: return {r[1], r[0]};
        endcase
    endfunction
    function automatic logic [2:0] steps_f(input logic [2:0] c, input logic [1:0] r, input logic m);
        if (c == fhr_pkg::WRITE_DELAY_SELECT_ZERO)
            return fhr_pkg::STEPS_NONE;
        if (c != fhr_pkg::WRITE_DELAY_SELECT_DEFAULT)
            return c;
        return (m || r == fhr_pkg::RATE_1M) ? fhr_pkg::STEPS_DEF_FAST : fhr_pkg::STEPS_DEF_SLOW;
    endfunction
    // counts soft reset pulses; more than one per write means it failed to self-clear
    always @(posedge clk_sys_i)
        if (soft_reset_o === 1'b1)
            soft_count <= soft_count + 1;
    // takes the oldest note whenever the host reports completion
    always @(negedge clk_sys_i)
    begin
        if (done_o === 1'b1 && exp_q.size() > 0)
        begin
            note = exp_q.pop_front();
            case (note[9:8])
                2'h0: check("data_byte_o", note[7:0], data_byte_o);
                2'h1: check("rdata_o", note[7:0], rdata_o);
                default: check("status read", note[7:0], rdata_o);
            endcase
        end
    end
    // main sequence, inputs change on the falling edge
    initial
    begin
        repeat (12) @(negedge clk_sys_i);
        srst_i = 1'b0;
        @(negedge clk_sys_i);
        check("rate_code_o", 8'(fhr_pkg::RATE_250), 8'(rate_code_o));
        check("write_delay_select_steps_o", 8'(fhr_pkg::STEPS_DEF_SLOW), 8'(write_delay_select_steps_o));
        check("fifo_enable_o", 8'h00, 8'(fifo_enable_o));
        for (int i = 0; i < 48; i++)
        begin
            v = (8'($random(seed)) & 8'h1c) | 8'(i[1:0]);
            b = 1'($random(seed));
            drive_type_code_i = i[3:2];
            drive_rate_setting_i = 2'(i / 16);
            two_meg_i = drive_rate_setting_i == fhr_pkg::DRT_2M && i[1:0] == fhr_pkg::RATE_300;
            write_delay_select_track_i = 8'($random(seed)) | 8'h01;
            cur_track_i = write_delay_select_track_i - 8'(b);
            host_op(1'b1, 1'b1, v);
            check("rate_code_o", 8'(i[1:0]), 8'(rate_code_o));
            check("density", 8'(dens_f(i[1:0])), 8'(density_select_out_o));
            check("pins", 8'(pins_f(i[1:0], i[3:2], dens_f(i[1:0]))), 8'(drive_density_pins_o));
            check("steps", 8'(b ? 3'h0 : steps_f(v[4:2], i[1:0], two_meg_i)), 8'(write_delay_select_steps_o));
            check("write_delay_select_fine_o", 8'(two_meg_i), 8'(write_delay_select_fine_o));
        end
        cfg_rate_i = fhr_pkg::RATE_500;
        cfg_rate_wr_i = 1'b1;
        fifo_cfg_en_i = 1'b1;
        fifo_cfg_wr_i = 1'b1;
        @(negedge clk_sys_i);
        cfg_rate_wr_i = 1'b0;
        fifo_cfg_wr_i = 1'b0;
        check("rate_code_o", 8'(fhr_pkg::RATE_500), 8'(rate_code_o));
        check("fifo_enable_o", 8'h01, 8'(fifo_enable_o));
        host_op(1'b1, 1'b1, v | 8'h40);
        check("low_power_o", 8'h01, 8'(low_power_o));
        host_op(1'b1, 1'b1, v | 8'h80);
        check("soft pulses", 8'h01, 8'(soft_count));
        check("low_power_o", 8'h00, 8'(low_power_o));
        check("fifo_enable_o", 8'h00, 8'(fifo_enable_o));
        check("rate_code_o", 8'(v[1:0]), 8'(rate_code_o));
        host_op(1'b1, 1'b1, v | 8'h40);
        for (int i = 0; i < 8; i++)
        begin
            {host_request_flag_i, transfer_direction_i, polled_exec_flag_i, cmd_busy_i, drive_seeking_flag_i} =
                8'($random(seed));
            exp_q.push_back({2'h2, host_request_flag_i, host_request_flag_i & transfer_direction_i,
                cmd_busy_i & polled_exec_flag_i, cmd_busy_i, drive_seeking_flag_i});
            host_op(1'b0, 1'b1, 8'h00);
        end
        check("low_power_o", 8'h00, 8'(low_power_o));
        // clock enable low: a config rate write must not land
        ce_i = 1'b0;
        cfg_rate_i = ~v[1:0];
        cfg_rate_wr_i = 1'b1;
        @(negedge clk_sys_i);
        cfg_rate_wr_i = 1'b0;
        ce_i = 1'b1;
        check("rate_code_o", 8'(v[1:0]), 8'(rate_code_o));
        for (int i = 0; i < 4; i++)
        begin
            v = 8'($random(seed));
            transfer_direction_i = i[0];
            result_byte_i = v;
            host_request_flag_i = 1'b0;
            exp_q.push_back({1'b0, i[0], v});
            fork
                host_op(~i[0], 1'b0, v);
                begin
                    repeat (5) @(negedge clk_sys_i);
                    check("data_wr_o", 8'h00, 8'(data_wr_o));
                    check("busy_o", 8'h01, 8'(busy_o));
                    host_request_flag_i = 1'b1;
                    @(negedge clk_sys_i);
                    check("data_rd_o", 8'(i[0]), 8'(data_rd_o));
                end
            join
            st = {1'b1, i[0], cmd_busy_i & polled_exec_flag_i, cmd_busy_i, drive_seeking_flag_i};
            check("status_o", st, status_o);
        end
        exec_start_i = 1'b1;
        xfer_error_i = 1'b1;
        #1;
        check("fifo_clear_o", 8'h01, 8'(fifo_clear_o));
        check("cmd_abort_o", 8'h01, 8'(cmd_abort_o));
        @(negedge clk_sys_i);
        exec_start_i = 1'b0;
        xfer_error_i = 1'b0;
        srst_i = 1'b1;
        @(negedge clk_sys_i);
        srst_i = 1'b0;
        @(negedge clk_sys_i);
        check("rate_code_o", 8'(fhr_pkg::RATE_250), 8'(rate_code_o));
        report_and_stop();
    end
endmodule
`default_nettype wire
